/* common/jsp_pkg.sv */
// package for the jtag scan port with emulator pins
// ****************************************************************
// ****************************************************************
package jsp_pkg;
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_EMUCTL = 4'h2;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int EMU_WIDTH = 4;
  localparam logic [3:0] EMU_RESET = 4'h0;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } jsp_tap_e;
  // emulator pin pair: output value, output enable
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } jsp_emu_s;
  typedef struct packed {
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] trst_sync;
    logic [1:0] emulator_event_pin_zero_sync;
    logic [1:0] emulator_event_pin_one_sync;
    logic trst_prev;
    jsp_tap_e tap;
    logic [3:0] ir_shift;
    logic [3:0] ir;
    logic [3:0] dr_shift;
    logic [3:0] emu_ctl;
    logic bypass;
    logic tdo;
    logic tdo_oe;
    logic bscan_mode;
  } jsp_state_s;
endpackage

/* rtl/jsp_top.sv */
// jtag tap with emulator event pins, sampled on core_clk
`timescale 1ns/1ps
module jsp_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic test_reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic emulator_event_pin_zero_in,
  output logic emulator_event_pin_zero_out,
  output logic emulator_event_pin_zero_oe,
  input wire logic emulator_event_pin_one_in,
  output logic emulator_event_pin_one_out,
  output logic emulator_event_pin_one_oe,
  input wire logic [1:0] emu_irq_out,
  output logic [1:0] emu_irq_in,
  output logic scan_control,
  output logic bscan_mode
);
  import jsp_pkg::*;
  jsp_state_s s, next_s;
  logic tck_rise, tck_fall, trst_on;

  // ****************************************************************
  // edge finding on synchronised pins
  // ****************************************************************
  // only stages 1 and 2 are read; stage 0 is the metastable one
  assign tck_rise = s.tck_sync[1] & ~s.tck_sync[2];
  assign tck_fall = ~s.tck_sync[1] & s.tck_sync[2];
  assign trst_on = s.trst_sync[1];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.tck_sync = {s.tck_sync[1:0], tck};
    next_s.tms_sync = {s.tms_sync[0], tms};
    next_s.tdi_sync = {s.tdi_sync[0], tdi};
    next_s.trst_sync = {s.trst_sync[0], test_reset};
    next_s.emulator_event_pin_zero_sync = {s.emulator_event_pin_zero_sync[0], emulator_event_pin_zero_in};
    next_s.emulator_event_pin_one_sync = {s.emulator_event_pin_one_sync[0], emulator_event_pin_one_in};
    next_s.trst_prev = trst_on;
    // pin levels at the rising test reset latch boundary scan
    if (trst_on && !s.trst_prev)
    begin
      next_s.bscan_mode = s.emulator_event_pin_zero_sync[1] & ~s.emulator_event_pin_one_sync[1];
    end
    if (!trst_on)
    begin
      // functional mode: tap parked; ir, emu_ctl, tdo_oe and bscan_mode reset
      next_s.tap = TEST_LOGIC_RESET;
      next_s.ir = IR_RESET;
      next_s.emu_ctl = EMU_RESET;
      next_s.tdo_oe = 1'b0;
      next_s.bscan_mode = 1'b0;
    end
    else if (tck_rise)
    begin
      // data capture/shift uses the tap state before this edge
      unique case (s.tap)
        CAPTURE_IR: next_s.ir_shift = {2'h0, IR_CAPTURE};
        SHIFT_IR: next_s.ir_shift = {s.tdi_sync[1], s.ir_shift[3:1]};
        UPDATE_IR: next_s.ir = s.ir_shift;
        CAPTURE_DR:
        begin
          next_s.bypass = 1'b0;
          next_s.dr_shift = {s.emulator_event_pin_one_sync[1], s.emulator_event_pin_zero_sync[1], s.emu_ctl[1:0]};
        end
        SHIFT_DR:
        begin
          next_s.bypass = s.tdi_sync[1];
          next_s.dr_shift = {s.tdi_sync[1], s.dr_shift[3:1]};
        end
        UPDATE_DR: if (s.ir == IR_EMUCTL) next_s.emu_ctl = s.dr_shift;
        TEST_LOGIC_RESET: next_s.ir = IR_RESET;
        default: ;
      endcase
      // standard sixteen-state walk on sampled tms
      unique case (s.tap)
        TEST_LOGIC_RESET: next_s.tap = s.tms_sync[1] ? TEST_LOGIC_RESET : RUN_IDLE;
        RUN_IDLE: next_s.tap = s.tms_sync[1] ? SELECT_DR : RUN_IDLE;
        SELECT_DR: next_s.tap = s.tms_sync[1] ? SELECT_IR : CAPTURE_DR;
        CAPTURE_DR: next_s.tap = s.tms_sync[1] ? EXIT1_DR : SHIFT_DR;
        SHIFT_DR: next_s.tap = s.tms_sync[1] ? EXIT1_DR : SHIFT_DR;
        EXIT1_DR: next_s.tap = s.tms_sync[1] ? UPDATE_DR : PAUSE_DR;
        PAUSE_DR: next_s.tap = s.tms_sync[1] ? EXIT2_DR : PAUSE_DR;
        EXIT2_DR: next_s.tap = s.tms_sync[1] ? UPDATE_DR : SHIFT_DR;
        UPDATE_DR: next_s.tap = s.tms_sync[1] ? SELECT_DR : RUN_IDLE;
        SELECT_IR: next_s.tap = s.tms_sync[1] ? TEST_LOGIC_RESET : CAPTURE_IR;
        CAPTURE_IR: next_s.tap = s.tms_sync[1] ? EXIT1_IR : SHIFT_IR;
        SHIFT_IR: next_s.tap = s.tms_sync[1] ? EXIT1_IR : SHIFT_IR;
        EXIT1_IR: next_s.tap = s.tms_sync[1] ? UPDATE_IR : PAUSE_IR;
        PAUSE_IR: next_s.tap = s.tms_sync[1] ? EXIT2_IR : PAUSE_IR;
        EXIT2_IR: next_s.tap = s.tms_sync[1] ? UPDATE_IR : SHIFT_IR;
        UPDATE_IR: next_s.tap = s.tms_sync[1] ? SELECT_DR : RUN_IDLE;
      endcase
    end
    else if (tck_fall)
    begin
      // tdo moves only on the falling edge, driven only while shifting
      next_s.tdo_oe = (s.tap == SHIFT_IR) || (s.tap == SHIFT_DR);
      if (s.tap == SHIFT_IR)
        next_s.tdo = s.ir_shift[0];
      else if (s.ir == IR_BYPASS)
        next_s.tdo = s.bypass;
      else
        next_s.tdo = s.dr_shift[0];
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.tap <= TEST_LOGIC_RESET;
      s.ir <= IR_RESET;
      s.emu_ctl <= EMU_RESET;
    end
    else
      s <= next_s;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign tdo = s.tdo;
  assign tdo_oe = s.tdo_oe;
  assign scan_control = trst_on;
  assign bscan_mode = s.bscan_mode;
  // emu_ctl[0]/[1] set pin direction; scan-written, so held off in func mode
  assign emulator_event_pin_zero_oe = s.emu_ctl[0] & trst_on;
  assign emulator_event_pin_zero_out = emu_irq_out[0];
  assign emulator_event_pin_one_oe = s.emu_ctl[1] & trst_on;
  assign emulator_event_pin_one_out = emu_irq_out[1];
  // inbound interrupts only when the pin is an input under scan control
  assign emu_irq_in[0] = trst_on & ~s.emu_ctl[0] & s.emulator_event_pin_zero_sync[1];
  assign emu_irq_in[1] = trst_on & ~s.emu_ctl[1] & s.emulator_event_pin_one_sync[1];

  // ****************************************************************
  // checks
  // ****************************************************************
  // oe moves on a falling edge or clears in func mode; judge the edge case there, not while it stands
  chk_tdo_only_shift: assert property (@(posedge core_clk) disable iff (rst)
    ($past(tck_fall) && $past(trst_on))
    |-> (tdo_oe == ($past(s.tap) inside {SHIFT_IR, SHIFT_DR})))
    else $error("tdo driven outside shift");
  chk_tdo_off_func: assert property (@(posedge core_clk) disable iff (rst)
    !$past(trst_on) |-> !tdo_oe)
    else $error("tdo driven in functional mode");
  chk_tdo_fall_edge: assert property (@(posedge core_clk) disable iff (rst)
    $changed(s.tdo) |-> $past(tck_fall))
    else $error("tdo changed off falling edge");
  chk_tap_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!tck_rise && trst_on && $past(trst_on)) |=> $stable(s.tap))
    else $error("tap moved without tck rise");
  chk_func_mode_reset: assert property (@(posedge core_clk) disable iff (rst)
    !trst_on |=> (s.tap == TEST_LOGIC_RESET && !bscan_mode))
    else $error("tap not parked in functional mode");
  chk_bscan_latch: assert property (@(posedge core_clk) disable iff (rst)
    (trst_on && !s.trst_prev && s.emulator_event_pin_zero_sync[1] && !s.emulator_event_pin_one_sync[1])
    |=> bscan_mode)
    else $error("boundary scan not latched");
  chk_bscan_no_latch: assert property (@(posedge core_clk) disable iff (rst)
    (trst_on && !s.trst_prev && !(s.emulator_event_pin_zero_sync[1] && !s.emulator_event_pin_one_sync[1]))
    |=> !bscan_mode)
    else $error("boundary scan latched wrongly");
  chk_tms_walk: assert property (@(posedge core_clk) disable iff (rst)
    (trst_on && tck_rise && s.tap == RUN_IDLE && s.tms_sync[1])
    |=> (s.tap == SELECT_DR))
    else $error("tms walk wrong");
  chk_emulator_event_pin_zero_dir: assert property (@(posedge core_clk) disable iff (rst)
    emulator_event_pin_zero_oe |-> (trst_on && s.emu_ctl[0]))
    else $error("pin zero driven without scan");
  chk_emulator_event_pin_one_dir: assert property (@(posedge core_clk) disable iff (rst)
    emulator_event_pin_one_oe |-> (scan_control && s.emu_ctl[1]))
    else $error("pin one driven without scan");
  chk_ir_shift_in: assert property (@(posedge core_clk) disable iff (rst)
    (trst_on && tck_rise && s.tap == SHIFT_IR)
    |=> (s.ir_shift[3] == $past(s.tdi_sync[1])))
    else $error("tdi not shifted into ir");
endmodule

/* sim/jsp_pod.sv */
// debugger pod model: scan pins, test reset, pulled-up emulator pins
`timescale 1ns/1ps
module jsp_pod
(
  input wire logic core_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [1:0] dev_out,
  input wire logic [1:0] dev_oe,
  output logic test_reset,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic [1:0] pin
);
  logic [1:0] ext_en;
  logic [1:0] ext_val;
  // a released pin floats to the pull-up level
  assign pin[0] = dev_oe[0] ? dev_out[0] : (ext_en[0] ? ext_val[0] : 1'b1);
  assign pin[1] = dev_oe[1] ? dev_out[1] : (ext_en[1] ? ext_val[1] : 1'b1);
  initial
  begin
    test_reset = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    ext_en = 2'b00;
    ext_val = 2'b00;
  end
  // ****************************************************************
  // pod actions
  // ****************************************************************
  // one 80 ns tck period; tdo read well after the falling edge
  task automatic step(input logic m, input logic d, output logic t,
                      output logic o);
    @(posedge core_clk);
    tms <= m;
    tdi <= d;
    @(posedge core_clk);
    tck <= 1'b1;
    repeat (8) @(posedge core_clk);
    tck <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    t = tdo;
    o = tdo_oe;
  endtask
  // pins held steady around the test reset edge
  task automatic set_trst(input logic v, input logic [1:0] p);
    ext_en <= 2'b11;
    ext_val <= p;
    repeat (4) @(posedge core_clk);
    test_reset <= v;
    repeat (8) @(posedge core_clk);
    ext_en <= 2'b00;
  endtask
endmodule

/* sim/jsp_top_test.sv */
// self-checking bench for the scan port and emulator pins
`timescale 1ns/1ps
module jsp_top_test;
  logic core_clk, rst, tdo, tdo_oe, scan_control, bscan_mode;
  logic test_reset, tck, tms, tdi, t, o;
  logic [1:0] pin, dev_out, dev_oe, emu_irq_out, emu_irq_in;
  logic [3:0] d, e;
  int err_total, num_checks;
  jsp_top u_jsp_top (.core_clk(core_clk), .rst(rst),
    .test_reset(test_reset), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .emulator_event_pin_zero_in(pin[0]),
    .emulator_event_pin_zero_out(dev_out[0]),
    .emulator_event_pin_zero_oe(dev_oe[0]),
    .emulator_event_pin_one_in(pin[1]),
    .emulator_event_pin_one_out(dev_out[1]),
    .emulator_event_pin_one_oe(dev_oe[1]), .emu_irq_out(emu_irq_out),
    .emu_irq_in(emu_irq_in), .scan_control(scan_control),
    .bscan_mode(bscan_mode));
  jsp_pod u_jsp_pod (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe),
    .dev_out(dev_out), .dev_oe(dev_oe), .test_reset(test_reset),
    .tck(tck), .tms(tms), .tdi(tdi), .pin(pin));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [3:0] x, input logic [3:0] g);
    num_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // from run-idle: capture, shift four bits lsb first, update, idle
  task automatic scan(input logic ir, input logic [3:0] din);
    u_jsp_pod.step(1'b1, 1'b0, t, o);
    if (ir)
      u_jsp_pod.step(1'b1, 1'b0, t, o);
    u_jsp_pod.step(1'b0, 1'b0, t, o);
    u_jsp_pod.step(1'b0, 1'b0, d[0], e[0]);
    for (int i = 0; i < 4; i++)
    begin
      u_jsp_pod.step(i == 3, din[i], t, o);
      if (i < 3)
      begin
        d[i+1] = t;
        e[i+1] = o;
      end
    end
    chk("tdo_oe_exit", 4'h0, {3'h0, o});
    u_jsp_pod.step(1'b1, 1'b0, t, o);
    u_jsp_pod.step(1'b0, 1'b0, t, o);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // tck traffic with test reset low must not reach the tap
  task automatic t_functional;
    scan(1'b1, 4'h2);
    chk("oe_func", 4'h0, e);
    chk("scan_control", 4'h0, {3'h0, scan_control});
  endtask
  // pin zero high, pin one low at the rise, then ir and dr scans
  task automatic t_scan;
    u_jsp_pod.set_trst(1'b1, 2'b01);
    chk("scan_control", 4'h1, {3'h0, scan_control});
    chk("bscan_mode", 4'h1, {3'h0, bscan_mode});
    u_jsp_pod.step(1'b0, 1'b0, t, o);
    scan(1'b1, 4'h2);
    chk("ir_capture", 4'h1, d);
    chk("ir_oe", 4'hf, e);
    emu_irq_out <= 2'b10;
    scan(1'b0, 4'h3);
    chk("dr_capture", 4'hc, d);
    chk("pin_drive", 4'h2, {2'h0, pin});
    scan(1'b0, 4'h0);
    chk("dr_ctl", 4'hb, d);
    u_jsp_pod.ext_en <= 2'b11;
    u_jsp_pod.ext_val <= 2'b01;
    repeat (6) @(posedge core_clk);
    chk("irq_in", 4'h1, {2'h0, emu_irq_in});
    u_jsp_pod.ext_en <= 2'b00;
  endtask
  // both pins high at the rise must not latch boundary scan
  task automatic t_no_bscan;
    u_jsp_pod.set_trst(1'b0, 2'b11);
    chk("scan_off", 4'h0, {3'h0, scan_control});
    u_jsp_pod.set_trst(1'b1, 2'b11);
    chk("bscan_mode", 4'h0, {3'h0, bscan_mode});
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    rst = 1'b1;
    emu_irq_out = 2'b00;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_functional();
    t_scan();
    t_no_bscan();
    wrap_up();
  end
endmodule
